/* hdl/fault_limit_response_regs.v */
// command registers for over-temperature and input over-voltage limits and actions
// assumes a byte-wide command port decoded from the bus layer, one command per strobe
// and telemetry words in the same linear format as the limits
`timescale 1ns/10ps
`include "fault_limit_defs.vh"

module fault_limit_response_regs (
  input wire sys_clk,
  input wire rst_n,
  input wire cmd_wr,
  input wire cmd_rd,
  input wire [7:0] cmd_code,
  input wire [15:0] cmd_wdata,
  input wire [15:0] temp_meas,
  input wire [15:0] vin_meas,
  input wire fault_clear,
  output reg [15:0] cmd_rdata,
  output reg cmd_rvalid,
  output reg cmd_unsupported,
  output reg data_rejected,
  output reg ot_warning,
  output reg ot_fault,
  output reg vin_ov_fault,
  output reg output_disable,
  output reg fault_latched
);

  reg [7:0] overtemp_action_reg;
  reg [15:0] overtemp_alarm_threshold_reg;
  reg [15:0] overtemp_fault_threshold_reg;
  reg [15:0] input_overvolt_threshold_reg;
  reg [7:0] input_overvolt_action_reg;
  reg [15:0] tick_cnt_reg;
  reg tick_reg;
  reg [15:0] rdata_next;
  reg known;
  wire temp_ok;
  wire vin_ok;
  wire ot_dis;
  wire ov_dis;
  wire ot_lat;
  wire ov_lat;
  wire [1:0] overtemp_response_sel;
  wire [2:0] overtemp_retry_sel;
  wire [2:0] overtemp_delay_sel;
  wire [1:0] input_overvolt_response_sel;
  wire [2:0] input_overvolt_retry_sel;
  wire [2:0] input_overvolt_delay_sel;

  // action fields
  assign overtemp_response_sel = overtemp_action_reg[`RSP_MSB:`RSP_LSB];
  assign overtemp_retry_sel = overtemp_action_reg[`RTY_MSB:`RTY_LSB];
  assign overtemp_delay_sel = overtemp_action_reg[`DLY_MSB:`DLY_LSB];
  assign input_overvolt_response_sel = input_overvolt_action_reg[`RSP_MSB:`RSP_LSB];
  assign input_overvolt_retry_sel = input_overvolt_action_reg[`RTY_MSB:`RTY_LSB];
  assign input_overvolt_delay_sel = input_overvolt_action_reg[`DLY_MSB:`DLY_LSB];

  // temperature limits share one range
  linear_range_check #(
    .EXPONENT(`EXP_TEMP),
    .MANT_MIN(`TEMP_MANT_MIN),
    .MANT_MAX(`TEMP_MANT_MAX)
  ) u_temp_chk (
    .word(cmd_wdata),
    .ok(temp_ok)
  );

  // voltage limit
  linear_range_check #(
    .EXPONENT(`EXP_VIN),
    .MANT_MIN(`VIN_MANT_MIN),
    .MANT_MAX(`VIN_MANT_MAX)
  ) u_vin_chk (
    .word(cmd_wdata),
    .ok(vin_ok)
  );

  // command writes with range screening
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overtemp_action_reg <= `DEF_OT_ACTION;
      overtemp_alarm_threshold_reg <= `DEF_OT_ALARM_LIMIT;
      overtemp_fault_threshold_reg <= `DEF_OT_FAULT_LIMIT;
      input_overvolt_threshold_reg <= `DEF_VIN_OV_LIMIT;
      input_overvolt_action_reg <= `DEF_VIN_OV_ACTION;
      data_rejected <= 1'b0;
    end
    else
    begin
      data_rejected <= 1'b0;
      if (cmd_wr)
      begin
        case (cmd_code)
          `CMD_OT_ACTION:
            overtemp_action_reg <= cmd_wdata[7:0];
          `CMD_VIN_OV_ACTION:
            input_overvolt_action_reg <= cmd_wdata[7:0];
          `CMD_OT_ALARM_LIMIT:
            if (temp_ok)
              overtemp_alarm_threshold_reg <= cmd_wdata;
            else
              data_rejected <= 1'b1;
          `CMD_OT_FAULT_LIMIT:
            if (temp_ok)
              overtemp_fault_threshold_reg <= cmd_wdata;
            else
              data_rejected <= 1'b1;
          `CMD_VIN_OV_LIMIT:
            if (vin_ok)
              input_overvolt_threshold_reg <= cmd_wdata;
            else
              data_rejected <= 1'b1;
          default:
            data_rejected <= 1'b0;
        endcase
      end
    end
  end

  // read mux
  always @*
  begin
    rdata_next = 16'h0000;
    known = 1'b1;
    case (cmd_code)
      `CMD_OT_ACTION: rdata_next = {8'h00, overtemp_action_reg};
      `CMD_OT_ALARM_LIMIT: rdata_next = overtemp_alarm_threshold_reg;
      `CMD_OT_FAULT_LIMIT: rdata_next = overtemp_fault_threshold_reg;
      `CMD_VIN_OV_LIMIT: rdata_next = input_overvolt_threshold_reg;
      `CMD_VIN_OV_ACTION: rdata_next = {8'h00, input_overvolt_action_reg};
      default: known = 1'b0;
    endcase
  end

  // read answer registered one cycle after the strobe
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_rdata <= 16'h0000;
      cmd_rvalid <= 1'b0;
      cmd_unsupported <= 1'b0;
    end
    else
    begin
      cmd_rvalid <= cmd_rd;
      cmd_unsupported <= (cmd_rd | cmd_wr) & ~known;
      if (cmd_rd)
        cmd_rdata <= rdata_next;
    end
  end

  // limits share exponent with telemetry, so compare signed mantissas
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ot_warning <= 1'b0;
      ot_fault <= 1'b0;
      vin_ov_fault <= 1'b0;
    end
    else
    begin
      ot_warning <= $signed(temp_meas[10:0]) >=
                    $signed(overtemp_alarm_threshold_reg[10:0]);
      ot_fault <= $signed(temp_meas[10:0]) >=
                  $signed(overtemp_fault_threshold_reg[10:0]);
      vin_ov_fault <= $signed(vin_meas[10:0]) >=
                      $signed(input_overvolt_threshold_reg[10:0]);
    end
  end

  // 1 ms tick for restart delays
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end
    else if (tick_cnt_reg == `DLY_UNIT_CYCLES - 1)
    begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // over-temperature reaction
  fault_action_unit u_ot_act (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .action(overtemp_action_reg),
    .fault(ot_fault),
    .tick(tick_reg),
    .clear(fault_clear),
    .disable_out(ot_dis),
    .latched(ot_lat)
  );

  // over-voltage reaction, same decode
  fault_action_unit u_ov_act (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .action(input_overvolt_action_reg),
    .fault(vin_ov_fault),
    .tick(tick_reg),
    .clear(fault_clear),
    .disable_out(ov_dis),
    .latched(ov_lat)
  );

  // combined power-stage controls
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      output_disable <= 1'b0;
      fault_latched <= 1'b0;
    end
    else
    begin
      output_disable <= ot_dis | ov_dis;
      fault_latched <= ot_lat | ov_lat;
    end
  end

endmodule

/* include/fault_limit_defs.vh */
// command codes, field positions, nonvolatile defaults and limits of the fault-limit bank
// included by every design file of this bank
`ifndef FAULT_LIMIT_DEFS_VH
`define FAULT_LIMIT_DEFS_VH

`define CMD_OT_FAULT_LIMIT 8'h4F
`define CMD_OT_ACTION 8'h50
`define CMD_OT_ALARM_LIMIT 8'h51
`define CMD_VIN_OV_LIMIT 8'h55
`define CMD_VIN_OV_ACTION 8'h56

`define DEF_OT_FAULT_LIMIT 16'h007D
`define DEF_OT_ACTION 8'hF9
`define DEF_OT_ALARM_LIMIT 16'h0069
`define DEF_VIN_OV_LIMIT 16'hF81E
`define DEF_VIN_OV_ACTION 8'hB8

`define RSP_MSB 7
`define RSP_LSB 6
`define RTY_MSB 5
`define RTY_LSB 3
`define DLY_MSB 2
`define DLY_LSB 0

`define RSP_CONTINUE 2'h0
`define RSP_SHUTDOWN 2'h3
`define RTY_FOREVER 3'h7

`define EXP_TEMP 5'h00
`define EXP_VIN 5'h1F
`define TEMP_MANT_MIN 11'h000
`define TEMP_MANT_MAX 11'h096
`define VIN_MANT_MIN 11'h002
`define VIN_MANT_MAX 11'h0A0

// restart delay unit: 1 ms at 25 MHz
`define DLY_UNIT_NS 1000000
`define CLK_PERIOD_NS 40
`define DLY_UNIT_CYCLES (`DLY_UNIT_NS / `CLK_PERIOD_NS)

`endif

/* hdl/linear_range_check.v */
// checks a linear-format word against a fixed exponent and a mantissa window
// assumes a combinational check; caller registers the outcome
`timescale 1ns/10ps
`include "fault_limit_defs.vh"

module linear_range_check #(
  parameter [4:0] EXPONENT = 5'h00,
  parameter [10:0] MANT_MIN = 11'h000,
  parameter [10:0] MANT_MAX = 11'h000
) (
  input wire [15:0] word,
  output wire ok
);

  // exponent must match and mantissa must sit inside the window
  assign ok = (word[15:11] == EXPONENT) && (word[10] == 1'b0) &&
              (word[10:0] >= MANT_MIN) && (word[10:0] <= MANT_MAX);

endmodule

/* hdl/fault_action_unit.v */
// turns an action byte and a fault level into output disable and restart behaviour
// assumes fault level synchronous to sys_clk and a 1 ms tick
`timescale 1ns/10ps
`include "fault_limit_defs.vh"

module fault_action_unit (
  input wire sys_clk,
  input wire rst_n,
  input wire [7:0] action,
  input wire fault,
  input wire tick,
  input wire clear,
  output reg disable_out,
  output reg latched
);

  localparam ST_RUN = 2'h0;
  localparam ST_OFF = 2'h1;
  localparam ST_WAIT = 2'h2;
  localparam ST_LOCK = 2'h3;

  reg [1:0] state_reg;
  reg [2:0] dly_reg;
  wire [1:0] rsp;
  wire [2:0] rty;
  wire [2:0] dly;

  assign rsp = action[`RSP_MSB:`RSP_LSB];
  assign rty = action[`RTY_MSB:`RTY_LSB];
  assign dly = action[`DLY_MSB:`DLY_LSB];

  // response sequencer
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_RUN;
      dly_reg <= 3'h0;
      disable_out <= 1'b0;
      latched <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_RUN:
        begin
          disable_out <= 1'b0;
          // continue operation on response 00
          if (fault && rsp != `RSP_CONTINUE)
          begin
            disable_out <= 1'b1;
            state_reg <= ST_OFF;
          end
        end
        ST_OFF:
        begin
          if (rty == 3'h0 && dly == 3'h0)
          begin
            latched <= 1'b1;
            state_reg <= ST_LOCK;
          end
          else if (!fault)
          begin
            dly_reg <= dly;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          // hiccup delay in 1 ms steps, then re-enable
          if (fault)
            state_reg <= ST_OFF;
          else if (dly_reg == 3'h0)
          begin
            disable_out <= 1'b0;
            state_reg <= ST_RUN;
          end
          else if (tick)
            dly_reg <= dly_reg - 3'h1;
        end
        ST_LOCK:
        begin
          // output held off until software clears while the fault is gone
          if (clear && !fault)
          begin
            latched <= 1'b0;
            disable_out <= 1'b0;
            state_reg <= ST_RUN;
          end
        end
        default:
          state_reg <= ST_RUN;
      endcase
    end
  end

endmodule

/* sim/pmbus_host_model.sv */
// host-side command master: one strobe per command, answer sampled after it
// assumes the answer is registered on the same edge that takes the strobe
`timescale 1ns/10ps
module pmbus_host_model (
  input wire sys_clk,
  output reg cmd_wr,
  output reg cmd_rd,
  output reg [7:0] cmd_code,
  output reg [15:0] cmd_wdata,
  input wire [15:0] cmd_rdata,
  input wire cmd_rvalid,
  input wire cmd_unsupported,
  input wire data_rejected
);
  // idle bus at time zero
  initial
  begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // write, return {unsupported, rejected}; released lines show inverted data
  task wr(input [7:0] c, input [15:0] d, output [1:0] st);
  begin
    @(posedge sys_clk);
    cmd_wr <= 1'b1;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge sys_clk);
    cmd_wr <= 1'b0;
    cmd_code <= ~c;
    cmd_wdata <= ~d;
    #1 st = {cmd_unsupported, data_rejected};
  end
  endtask
  // read, return {valid, data}
  task rd(input [7:0] c, output [16:0] r);
  begin
    @(posedge sys_clk);
    cmd_rd <= 1'b1;
    cmd_code <= c;
    @(posedge sys_clk);
    cmd_rd <= 1'b0;
    cmd_code <= ~c;
    #1 r = {cmd_rvalid, cmd_rdata};
  end
  endtask
endmodule

/* sim/fault_limit_checker_assertions.sv */
// port-level checks of the fault-limit command bank
// assumes one clock and the bank's command codes
`timescale 1ns/10ps
module fault_limit_checker (
  input wire sys_clk,
  input wire rst_n,
  input wire cmd_wr,
  input wire cmd_rd,
  input wire [7:0] cmd_code,
  input wire [15:0] cmd_wdata,
  input wire fault_clear,
  input wire cmd_rvalid,
  input wire data_rejected,
  input wire ot_fault,
  input wire vin_ov_fault,
  input wire output_disable,
  input wire fault_latched
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // decode helpers for the request being taken
  wire known = cmd_code inside {8'h4F, 8'h50, 8'h51, 8'h55, 8'h56};
  wire bad_t = cmd_wdata[15:11] != 5'h00 || cmd_wdata[10:0] > 11'h096;
  wire bad_v = cmd_wdata[15:11] != 5'h1F || cmd_wdata[10:0] < 11'h002
    || cmd_wdata[10:0] > 11'h0A0;
  reg [7:0] ot_act_reg;
  reg [7:0] vin_act_reg;
  // shadow copies of both action bytes
  always @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
    begin
      ot_act_reg <= 8'hF9;
      vin_act_reg <= 8'hB8;
    end
    else if (cmd_wr)
    begin
      if (cmd_code == 8'h50) ot_act_reg <= cmd_wdata[7:0];
      if (cmd_code == 8'h56) vin_act_reg <= cmd_wdata[7:0];
    end
  rd_answer_a: assert property (cmd_rd && known |=> cmd_rvalid)
    else $error("read not answered");
  temp_limit_a: assert property (cmd_wr && cmd_code == 8'h51 |=> data_rejected == $past(bad_t))
    else $error("alarm limit check wrong");
  vin_limit_a: assert property (cmd_wr && cmd_code == 8'h55 |=> data_rejected == $past(bad_v))
    else $error("overvolt limit check wrong");
  action_accept_a: assert property (cmd_wr && cmd_code[2:0] inside {3'h0, 3'h6} && known
    |=> !data_rejected)
    else $error("action byte refused");
  keep_running_a: assert property ((ot_act_reg[7:6] == 2'h0 && vin_act_reg[7:6] == 2'h0
    && !fault_latched) [*4] |-> !output_disable)
    else $error("output off with continue response");
  ot_react_a: assert property (ot_fault && ot_act_reg[7:6] != 2'h0 |-> ##[0:4] output_disable)
    else $error("no shutdown on overtemp");
  vin_react_a: assert property (vin_ov_fault && vin_act_reg[7:6] != 2'h0
    |-> ##[0:4] output_disable)
    else $error("no shutdown on overvolt");
  latch_off_a: assert property (fault_latched |-> output_disable)
    else $error("latched but output on");
  latch_hold_a: assert property (fault_latched && !fault_clear && !$past(fault_clear) && !cmd_wr
    |=> fault_latched)
    else $error("latch released without clear");
endmodule
bind fault_limit_response_regs fault_limit_checker fault_limit_checker_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
  .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .fault_clear(fault_clear),
  .cmd_rvalid(cmd_rvalid), .data_rejected(data_rejected), .ot_fault(ot_fault),
  .vin_ov_fault(vin_ov_fault), .output_disable(output_disable),
  .fault_latched(fault_latched));

/* sim/fault_limit_response_regs_tb.sv */
// self-checking bench for the fault-limit command bank
// assumes the host model and the checker files are compiled before it
`timescale 1ns/10ps
module fault_limit_response_regs_tb;
  reg sys_clk = 1'b0;
  reg rst_n = 1'b0;
  reg [15:0] temp_meas = 16'h0000;
  reg [15:0] vin_meas = 16'h0000;
  reg fault_clear = 1'b0;
  wire cmd_wr, cmd_rd, cmd_rvalid, cmd_unsupported, data_rejected;
  wire ot_warning, ot_fault, vin_ov_fault, output_disable, fault_latched;
  wire [7:0] cmd_code;
  wire [15:0] cmd_wdata, cmd_rdata;
  reg [1:0] s;
  reg [16:0] r;
  integer num_errors = 0;
  integer samples_checked = 0;
  integer i;
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  fault_limit_response_regs fault_limit_response_regs_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .temp_meas(temp_meas), .vin_meas(vin_meas), .fault_clear(fault_clear),
    .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid), .cmd_unsupported(cmd_unsupported),
    .data_rejected(data_rejected), .ot_warning(ot_warning), .ot_fault(ot_fault),
    .vin_ov_fault(vin_ov_fault), .output_disable(output_disable),
    .fault_latched(fault_latched));
  pmbus_host_model pmbus_host_model_inst (.sys_clk(sys_clk), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .cmd_unsupported(cmd_unsupported),
    .data_rejected(data_rejected));
  task chk(input [16:0] got, input [16:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  // write with expected status, then read back expected value
  task thr(input [7:0] c, input [15:0] d, input [1:0] st, input [15:0] e);
  begin
    pmbus_host_model_inst.wr(c, d, s);
    chk({15'h0000, s}, {15'h0000, st});
    pmbus_host_model_inst.rd(c, r);
    chk(r, {1'b1, e});
  end
  endtask
  // wait n cycles, compare {warn, fault, ov, disable, latched}
  task obs(input integer n, input [4:0] e);
  begin
    repeat (n) @(posedge sys_clk);
    #1 chk({12'h000, ot_warning, ot_fault, vin_ov_fault, output_disable, fault_latched},
      {12'h000, e});
  end
  endtask
  task test_done;
  begin
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // watchdog well past the 1 ms restart delay the sequence waits for
  initial
  begin
    repeat (90000) @(posedge sys_clk);
    num_errors = num_errors + 1;
    test_done;
  end
  // main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    pmbus_host_model_inst.rd(8'h50, r); chk(r, 17'h100F9);
    pmbus_host_model_inst.rd(8'h51, r); chk(r, 17'h10069);
    pmbus_host_model_inst.rd(8'h55, r); chk(r, 17'h1F81E);
    pmbus_host_model_inst.rd(8'h56, r); chk(r, 17'h100B8);
    pmbus_host_model_inst.rd(8'h4F, r); chk(r, 17'h1007D);
    pmbus_host_model_inst.wr(8'h52, 16'h0001, s); chk({15'h0000, s}, 17'h00002);
    thr(8'h51, 16'h0096, 2'h0, 16'h0096);
    thr(8'h51, 16'h0097, 2'h1, 16'h0096);
    thr(8'h51, 16'h0801, 2'h1, 16'h0096);
    thr(8'h51, 16'h07FF, 2'h1, 16'h0096);
    thr(8'h55, 16'hF802, 2'h0, 16'hF802);
    thr(8'h55, 16'hF801, 2'h1, 16'hF802);
    thr(8'h55, 16'hF8A1, 2'h1, 16'hF802);
    thr(8'h55, 16'h0010, 2'h1, 16'hF802);
    thr(8'h55, 16'hF8A0, 2'h0, 16'hF8A0);
    thr(8'h50, 16'h00FF, 2'h0, 16'h00FF);
    thr(8'h50, 16'h00F9, 2'h0, 16'h00F9);
    @(posedge sys_clk) temp_meas <= 16'h0096;
    obs(6, 5'b11010);
    @(posedge sys_clk) temp_meas <= 16'h0095;
    obs(4, 5'b01010);
    @(posedge sys_clk) temp_meas <= 16'h0000;
    for (i = 0; i < 30000 && output_disable !== 1'b0; i = i + 1) @(posedge sys_clk);
    obs(1, 5'b00000);
    thr(8'h50, 16'h00C0, 2'h0, 16'h00C0);
    @(posedge sys_clk) temp_meas <= 16'h0080;
    obs(6, 5'b01011);
    @(posedge sys_clk) temp_meas <= 16'h0000;
    obs(10, 5'b00011);
    @(posedge sys_clk) fault_clear <= 1'b1;
    @(posedge sys_clk) fault_clear <= 1'b0;
    obs(6, 5'b00000);
    thr(8'h50, 16'h00C8, 2'h0, 16'h00C8);
    @(posedge sys_clk) temp_meas <= 16'h0080;
    obs(6, 5'b01010);
    @(posedge sys_clk) temp_meas <= 16'h0000;
    for (i = 0; i < 30000 && output_disable !== 1'b0; i = i + 1) @(posedge sys_clk);
    obs(1, 5'b00000);
    thr(8'h50, 16'h0000, 2'h0, 16'h0000);
    thr(8'h56, 16'h0000, 2'h0, 16'h0000);
    @(posedge sys_clk) temp_meas <= 16'h0080;
    obs(8, 5'b01000);
    @(posedge sys_clk) temp_meas <= 16'h0000;
    thr(8'h56, 16'h00C0, 2'h0, 16'h00C0);
    @(posedge sys_clk) vin_meas <= 16'hF8A0;
    obs(6, 5'b00111);
    @(posedge sys_clk) vin_meas <= 16'hF810;
    obs(6, 5'b00011);
    @(posedge sys_clk) fault_clear <= 1'b1;
    @(posedge sys_clk) fault_clear <= 1'b0;
    obs(6, 5'b00000);
    test_done;
  end
endmodule
